//--- rtl/spg_defs.svh
// Constants of the shared pin general purpose port.
// Included by the port module.
`ifndef SPG_DEFS_SVH
`define SPG_DEFS_SVH

// Register indices; byte address is four times the index
`define SPG_ROUTING_IDX 8'h12
`define SPG_DIRECTION_IDX 8'h13
`define SPG_LEVEL_IDX 8'h14

// Reset values
`define SPG_ROUTING_RST 8'h00
`define SPG_DIRECTION_RST 8'h00
`define SPG_LEVEL_RST 8'h00

// Bus answers
`define SPG_RESP_OKAY 2'h0
`define SPG_RESP_SLVERR 2'h2

`endif

//--- rtl/spg_pkg.sv
// Types of the shared pin general purpose port.
// Needs nothing from its surroundings.
`default_nettype none
package spg_pkg;
    typedef logic [7:0] spg_byte_t;
    typedef enum logic [1:0] {
        SPG_SEL_NONE = 2'b00,
        SPG_SEL_ROUTING = 2'b01,
        SPG_SEL_DIRECTION = 2'b10,
        SPG_SEL_LEVEL = 2'b11
    } spg_sel_t;
endpackage : spg_pkg
`default_nettype wire

//--- rtl/spg_sync2.sv
// Two flip-flop synchroniser for the eight pin levels.
// Assumes one clock and an asynchronous active high reset.
`timescale 1ns/1ns
`default_nettype none
module spg_sync2 (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [7:0] d_i,
    output logic [7:0] q_o
);
    logic [7:0] meta_reg;
    logic [7:0] q_reg;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= 8'h00;
            q_reg <= 8'h00;
        end else begin
            meta_reg <= d_i;
            q_reg <= meta_reg;
        end
    end

    assign q_o = q_reg;
endmodule : spg_sync2
`default_nettype wire

//--- rtl/spg_port.sv
// Eight bit general purpose port on shared analog pins, AXI4-Lite slave.
// Assumes a single 10 MHz clock and an external pad that resolves pin enables.
//
// Notes on behaviour
// - Routing bit 0 connects port bit 0 to analog pin 3, else disconnected, default off.
// - Routing bits 1 and 2 connect port bits 1 and 2 to analog pins 4 and 5.
// - Routing bits 3 and 4 connect port bits 3 and 4 to analog pins 6 and 7.
// - Routing bits 5 and 6 connect port bits 5 and 6 to analog pins 8 and 9.
// - Routing bit 7 connects port bit 7 to the analog common pin, default off.
// - A direction bit of zero makes its bit an output, one an input, all outputs after reset.
// - The direction register sits at index 13h and resets to 00h.
// - An output bit reads back the stored level value.
// - Writing an input bit only updates the stored value and never drives the pin.
// - A level bit of zero means low and one means high.
// - The level register sits at index 14h and resets to 00h.
// - The routing register sits at index 12h and resets to 00h.
`timescale 1ns/1ns
`default_nettype none
`include "spg_defs.svh"
module spg_port
    import spg_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    // AXI4-Lite write address
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [7:0] AWADDR_I,
    // AXI4-Lite write data
    input wire logic WVALID_I,
    output logic WREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    // AXI4-Lite write response
    output logic BVALID_O,
    input wire logic BREADY_I,
    output logic [1:0] BRESP_O,
    // AXI4-Lite read address
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    input wire logic [7:0] ARADDR_I,
    // AXI4-Lite read data
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    // Shared analog pins 3..9 and common, bit 7 is the common pin
    input wire logic [7:0] ANALOG_PIN_I,
    output logic [7:0] ANALOG_PIN_O,
    output logic [7:0] ANALOG_PIN_OE_O
);
    // Address decode
    function automatic spg_sel_t reg_sel(input logic [7:0] addr);
        spg_sel_t sel;
        sel = SPG_SEL_NONE;
        if ({2'b00, addr} == {`SPG_ROUTING_IDX, 2'b00}) begin
            sel = SPG_SEL_ROUTING;
        end else if ({2'b00, addr} == {`SPG_DIRECTION_IDX, 2'b00}) begin
            sel = SPG_SEL_DIRECTION;
        end else if ({2'b00, addr} == {`SPG_LEVEL_IDX, 2'b00}) begin
            sel = SPG_SEL_LEVEL;
        end
        return sel;
    endfunction : reg_sel

    // Registers
    spg_byte_t routing_reg;
    spg_byte_t direction_reg;
    spg_byte_t level_reg;
    spg_byte_t pin_out_reg;
    spg_byte_t pin_oe_reg;
    spg_byte_t pin_sync;

    // Bus state
    logic aw_held_reg;
    logic [7:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Write path
    wire logic aw_take = AWVALID_I & awready_reg;
    wire logic w_take = WVALID_I & wready_reg;
    wire logic aw_have = aw_held_reg | aw_take;
    wire logic w_have = w_held_reg | w_take;
    wire logic do_write = aw_have & w_have & ~bvalid_reg;
    wire logic [7:0] wr_addr = aw_take ? AWADDR_I : aw_addr_reg;
    wire logic [31:0] wr_data = w_take ? WDATA_I : w_data_reg;
    wire logic [3:0] wr_strb = w_take ? WSTRB_I : w_strb_reg;
    wire spg_sel_t wr_sel = reg_sel(wr_addr);
    wire logic wr_lane = do_write & wr_strb[0];
    wire logic aw_held_next = aw_have & ~do_write;
    wire logic w_held_next = w_have & ~do_write;
    wire logic bvalid_next = do_write | (bvalid_reg & ~BREADY_I);
    wire logic [1:0] bresp_next = (wr_sel == SPG_SEL_NONE) ? `SPG_RESP_SLVERR : `SPG_RESP_OKAY;

    // Register next values; a level write is stored whatever the direction
    wire spg_byte_t routing_next =
        (wr_lane && wr_sel == SPG_SEL_ROUTING) ? wr_data[7:0] : routing_reg;
    wire spg_byte_t direction_next =
        (wr_lane && wr_sel == SPG_SEL_DIRECTION) ? wr_data[7:0] : direction_reg;
    wire spg_byte_t level_next =
        (wr_lane && wr_sel == SPG_SEL_LEVEL) ? wr_data[7:0] : level_reg;

    // Pin drive: routed and output bits only
    wire spg_byte_t pin_oe_next = routing_next & ~direction_next;
    wire spg_byte_t pin_out_next = level_next & pin_oe_next;

    // Read path
    wire logic ar_take = ARVALID_I & arready_reg;
    wire spg_sel_t rd_sel = reg_sel(ARADDR_I);
    wire spg_byte_t level_view =
        (level_reg & ~direction_reg) | (pin_sync & direction_reg & routing_reg);
    wire spg_byte_t rd_byte =
        (rd_sel == SPG_SEL_ROUTING) ? routing_reg :
        (rd_sel == SPG_SEL_DIRECTION) ? direction_reg :
        (rd_sel == SPG_SEL_LEVEL) ? level_view : 8'h00;
    wire logic rvalid_next = ar_take | (rvalid_reg & ~RREADY_I);
    wire logic [1:0] rresp_next = (rd_sel == SPG_SEL_NONE) ? `SPG_RESP_SLVERR : `SPG_RESP_OKAY;

    // Pin level sampling
    spg_sync2 u_sync (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .d_i(ANALOG_PIN_I),
        .q_o(pin_sync)
    );

    // Port registers
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            routing_reg <= `SPG_ROUTING_RST;
            direction_reg <= `SPG_DIRECTION_RST;
            level_reg <= `SPG_LEVEL_RST;
            pin_out_reg <= 8'h00;
            pin_oe_reg <= 8'h00;
        end else begin
            routing_reg <= routing_next;
            direction_reg <= direction_next;
            level_reg <= level_next;
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // Write channel state
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SPG_RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awready_reg <= ~aw_held_next & ~bvalid_next;
            wready_reg <= ~w_held_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (do_write) begin
                bresp_reg <= bresp_next;
            end
        end
    end

    // Held write payload
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= AWADDR_I;
            end
            if (w_take) begin
                w_data_reg <= WDATA_I;
                w_strb_reg <= WSTRB_I;
            end
        end
    end

    // Read channel state
    always_ff @(posedge REF_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SPG_RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= {24'h00_0000, rd_byte};
                rresp_reg <= rresp_next;
            end
        end
    end

    // Outputs
    assign AWREADY_O = awready_reg;
    assign WREADY_O = wready_reg;
    assign BVALID_O = bvalid_reg;
    assign BRESP_O = bresp_reg;
    assign ARREADY_O = arready_reg;
    assign RVALID_O = rvalid_reg;
    assign RDATA_O = rdata_reg;
    assign RRESP_O = rresp_reg;
    assign ANALOG_PIN_O = pin_out_reg;
    assign ANALOG_PIN_OE_O = pin_oe_reg;
endmodule : spg_port
`default_nettype wire

//--- tb/spg_port_properties.sv
// Checker for the port bus answers and pin enables.
// Bound to spg_port; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module spg_port_props (
    input wire logic REF_CLK_I, RST_I, AWVALID_I, AWREADY_O, WVALID_I,
    input wire logic WREADY_O, BVALID_O, ARVALID_I, ARREADY_O, RVALID_O,
    input wire logic [7:0] AWADDR_I, ARADDR_I, ANALOG_PIN_O, ANALOG_PIN_OE_O,
    input wire logic [31:0] WDATA_I, RDATA_O,
    input wire logic [3:0] WSTRB_I,
    input wire logic [1:0] BRESP_O, RRESP_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    wire logic wt = AWVALID_I & AWREADY_O & WVALID_I & WREADY_O;
    wire logic wmap = AWADDR_I inside {8'h48, 8'h4C, 8'h50};
    wire logic rmap = ARADDR_I inside {8'h48, 8'h4C, 8'h50};
    sequence s_wr(a);
        wt && WSTRB_I[0] && AWADDR_I == a;
    endsequence
    a_b_okay: assert property (wt && wmap |=> BVALID_O && BRESP_O == 2'h0)
        else $error("write to a register not answered OKAY");
    a_b_err: assert property (wt && !wmap |=> BVALID_O && BRESP_O == 2'h2)
        else $error("unmapped write not answered SLVERR");
    a_r_err: assert property (ARVALID_I && ARREADY_O && !rmap
        |=> RVALID_O && RRESP_O == 2'h2 && RDATA_O == 0) else $error("bad unmapped read");
    a_ready_back: assert property ($fell(BVALID_O) |-> AWREADY_O && WREADY_O)
        else $error("readies not back after response");
    a_busy_refuse: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
        else $error("write taken while response pending");
    a_route_out: assert property (s_wr(8'h48)
        |=> ({24'h0, ANALOG_PIN_OE_O} & ~$past(WDATA_I)) == 0) else $error("unrouted pin driven");
    a_dir_in: assert property (s_wr(8'h4C)
        |=> ({24'h0, ANALOG_PIN_OE_O} & $past(WDATA_I)) == 0) else $error("input pin driven");
    a_lvl_out: assert property (s_wr(8'h50) |=>
        (({24'h0, ANALOG_PIN_O} ^ $past(WDATA_I)) & ANALOG_PIN_OE_O) == 0)
        else $error("driven level differs");
endmodule : spg_port_props
bind spg_port spg_port_props i_props (.*);
`default_nettype wire

//--- tb/spg_pin_model.sv
// Model of the outside circuitry on the shared pins.
// Assumes the device drives a pin only where its enable is high.
`timescale 1ns/1ns
`default_nettype none
module spg_pin_model (
    // Device side
    input wire logic [7:0] oe_i,
    input wire logic [7:0] drv_i,
    // Outside level and resolved pin
    input wire logic [7:0] ext_i,
    output logic [7:0] pin_o
);
    // Device wins where it drives
    assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : spg_pin_model
`default_nettype wire

//--- tb/shared_pin_gpio_port_test.sv
// Random bench for spg_port over AXI4-Lite.
// Assumes design, checker and pin model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module shared_pin_gpio_port_test;
    logic REF_CLK_I = 0, RST_I = 1, AWVALID_I = 0, WVALID_I = 0, ARVALID_I = 0;
    logic BREADY_I = 1, RREADY_I = 1;
    logic [7:0] AWADDR_I = 0, ARADDR_I = 0, ext = 0, r, d, l;
    logic [31:0] WDATA_I = 0, v, q;
    logic [3:0] WSTRB_I = 4'h1;
    logic [1:0] rsp;
    wire logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
    wire logic [1:0] BRESP_O, RRESP_O;
    wire logic [31:0] RDATA_O;
    wire logic [7:0] ANALOG_PIN_I, ANALOG_PIN_O, ANALOG_PIN_OE_O;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    integer seed = 32'h4bc1_c65d;
    spg_port i_dut (.*);
    spg_pin_model i_pins (.oe_i(ANALOG_PIN_OE_O), .drv_i(ANALOG_PIN_O), .ext_i(ext),
        .pin_o(ANALOG_PIN_I));
    initial forever #50 REF_CLK_I = ~REF_CLK_I;
    always @(posedge REF_CLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        AWVALID_I <= 1;
        WVALID_I <= 1;
        AWADDR_I <= a;
        WDATA_I <= x;
        forever begin
            @(posedge REF_CLK_I);
            if (AWREADY_O) AWVALID_I <= 0;
            if (WREADY_O) WVALID_I <= 0;
            if (BVALID_O) break;
        end
        rsp = BRESP_O;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        ARVALID_I <= 1;
        ARADDR_I <= a;
        forever begin
            @(posedge REF_CLK_I);
            if (ARREADY_O) ARVALID_I <= 0;
            if (RVALID_O) break;
        end
        q = RDATA_O;
        rsp = RRESP_O;
    endtask : rd
    function automatic logic [31:0] exp_lvl(input logic [7:0] rt, dr, lv, ex);
        return {24'h0, (lv & ~dr) | (ex & dr & rt)};
    endfunction : exp_lvl
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20) @(posedge REF_CLK_I);
        RST_I <= 0;
        @(posedge REF_CLK_I);
        chk("oe reset", 0, 32'(ANALOG_PIN_OE_O));
        rd(8'h48);
        chk("routing reset", 0, q);
        rd(8'h4C);
        chk("direction reset", 0, q);
        rd(8'h50);
        chk("level reset", 0, q);
        rd(8'h54);
        chk("unmapped rresp", 2, 32'(rsp));
        wr(8'h44, 1);
        chk("unmapped bresp", 2, 32'(rsp));
        WSTRB_I <= 4'h0;
        wr(8'h48, 32'h0000_00FF);
        WSTRB_I <= 4'h1;
        chk("strobe bresp", 0, 32'(rsp));
        rd(8'h48);
        chk("unstrobed write", 0, q);
        $display("Reset and map test done");
        for (int i = 0; i < 30; i++) begin
            r = i < 2 ? 8'hFF : 8'($random(seed));
            d = i < 2 ? {8{i[0]}} : 8'($random(seed));
            v = $random(seed);
            l = v[7:0];
            ext <= 8'($random(seed));
            wr(8'h48, 32'(r));
            wr(8'h4C, 32'(d));
            wr(8'h50, v);
            chk("bresp", 0, 32'(rsp));
            chk("oe", 32'(r & ~d), 32'(ANALOG_PIN_OE_O));
            chk("pin", 32'(l & r & ~d), 32'(ANALOG_PIN_O));
            rd(8'h48);
            chk("routing", 32'(r), q);
            rd(8'h4C);
            chk("direction", 32'(d), q);
            rd(8'h50);
            chk("level", exp_lvl(r, d, l, ext), q);
            chk("rresp", 0, 32'(rsp));
            wr(8'h4C, 0);
            rd(8'h50);
            chk("stored level", 32'(l), q);
            $display("Random test %0d done", i);
        end
        end_sim();
    end
endmodule : shared_pin_gpio_port_test
`default_nettype wire
